// File: core/splc_top.sv
// Safety parameter lock, apply-on-reset, consistency alarm and test/forced output control
// Contract
// - Default password is six zero characters until another is set.
// - New safety parameters take effect only after power cycle or software reset; the code applies them at software reset only, presetn loads zeros.
// - Parameter changes are rejected unless password authentication has passed.
// - Safety parameters are readable at any time without authentication.
// - Password holds up to six alphanumeric characters, compared case sensitively.
// - A new password becomes active only after the next reset; the code applies it at software reset only, presetn restores the default.
// - Password initialize restores default password and factory parameters at next reset.
// - Encoder resolution mismatch with the motor raises the setting-range alarm.
// - Rated speed mismatch while speed monitoring raises the setting-range alarm.
// - Safety polarity differing from normal travel direction raises the alarm.
// - Polarity 0 monitors increasing address, polarity 1 decreasing address.
// - Linear motor resolution numerator or denominator mismatch raises the alarm.
// - Linear motor encoder resolution is refused unless monitoring is used.
// - Input mode 2 is test mode, disabling I/O diagnosis and sub-functions.
// - Forced output is accepted only in input mode 2.
// - Forced outputs follow requested states regardless of servo status.
// - Paired A/B outputs switch together unless individual switching is chosen.
// - Activation 1 enables sub-functions and restricts the communication cycle.
// - Common setting method applies the latest written value to every axis.
// - Self-diagnosis error starts safe stop one using the decel monitor time.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "splc_regs.svh"
module splc_top #(
    parameter int MS_CYCLES = `SPLC_MS_NS / `SPLC_CLK_NS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Motor and normal parameter values per axis
    input wire logic [1:0][31:0] motor_enc_res,
    input wire logic [1:0][15:0] motor_rated_speed,
    input wire logic [1:0] normal_travel_direction,
    input wire logic [1:0][15:0] normal_lin_res_numerator,
    input wire logic [1:0][15:0] normal_lin_res_denominator,
    input wire logic [1:0] linear_motor,
    // Unit settings and diagnosis
    input wire logic common_setting,
    input wire logic selfdiag_error,
    input wire logic [7:0] servo_out,
    // Safety status per axis, one communication cycle restriction for the whole unit
    output logic [1:0] setting_range_alarm,
    output logic [1:0] test_mode,
    output logic [1:0] io_diag_enable,
    output logic [1:0] safety_func_enable,
    output logic [1:0] monitor_decreasing,
    output logic comm_cycle_restricted,
    // Safe stop one
    output logic safe_stop_one,
    output logic ss1_decel_done,
    // Safety outputs 1a,1b,2a,2b,3pa,3na,3pb,3nb in bit order 0..7
    output logic [7:0] safety_out
);
    typedef struct packed {
        splc_pkg::splc_param_t [1:0] pend;
        splc_pkg::splc_param_t [1:0] act;
        logic [47:0] pw_act;
        logic [47:0] pw_pend;
        logic [47:0] attempt;
        logic [47:0] newpw;
        logic auth;
        logic auth_fail;
        logic wr_refused;
        logic pw_init;
        logic dirty;
        logic axis_sel;
        logic force_en;
        logic [7:0] force_val;
        logic alarm0;
        logic alarm1;
        logic ss1;
        logic ss1_done;
        logic [15:0] ss1_cnt;
        logic [15:0] ms_cnt;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [7:0] sout;
        logic [1:0] tmode;
        logic [1:0] diag;
        logic [1:0] sfen;
        logic [1:0] direction_polarity;
        logic restrict_cc;
    } splc_state_t;

    splc_state_t s_ff;
    splc_state_t nxt_s;

    logic [1:0] mismatch;
    logic [5:0] char_ok;
    logic pw_valid;
    logic access;
    logic commit;
    logic [7:0] addr;
    splc_pkg::splc_param_t cur;
    logic [1:0] target;
    logic enc_refuse;

    // Consistency checker per axis
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_axis
            splc_chk_if cif ();
            assign cif.act = s_ff.act[gi];
            assign cif.motor_enc = motor_enc_res[gi];
            assign cif.motor_speed = motor_rated_speed[gi];
            assign cif.norm_dir = normal_travel_direction[gi];
            assign cif.norm_num = normal_lin_res_numerator[gi];
            assign cif.norm_den = normal_lin_res_denominator[gi];
            assign cif.linear = linear_motor[gi];
            assign mismatch[gi] = cif.mismatch;
            splc_check u_chk (
                .c(cif.chk)
            );
        end
    endgenerate

    // Alphanumeric check per character, zero bytes pad a shorter string
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_char
            logic [7:0] ch;
            assign ch = s_ff.newpw[gi*8 +: 8];
            assign char_ok[gi] = (ch == 8'h00) || (ch >= 8'h30 && ch <= 8'h39)
                || (ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h61 && ch <= 8'h7A);
        end
    endgenerate
    assign pw_valid = &char_ok;

    // APB phases: one wait state, commit at the edge that samples pready high
    assign access = psel && penable && !s_ff.pready;
    assign commit = psel && penable && s_ff.pready;
    assign addr = paddr[7:0];
    assign cur = s_ff.pend[s_ff.axis_sel];

    // Axes written by a parameter write
    assign target = common_setting ? 2'h3 : (s_ff.axis_sel ? 2'h2 : 2'h1);

    // Linear motor without position or speed monitoring cannot take an encoder resolution
    assign enc_refuse = (target[0] && linear_motor[0] && ~|s_ff.pend[0].cfg[`SPLC_CFG_MON_MSB:`SPLC_CFG_MON_LSB])
        || (target[1] && linear_motor[1] && ~|s_ff.pend[1].cfg[`SPLC_CFG_MON_MSB:`SPLC_CFG_MON_LSB]);

    // Next state
    always_comb
    begin
        logic is_param;
        logic refuse;
        logic unmapped;
        logic [31:0] rd;
        is_param = 1'b0;
        refuse = 1'b0;
        unmapped = 1'b0;
        rd = 32'h0000_0000;
        nxt_s = s_ff;
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;

        // Decode: reads never need authentication
        unique case (addr)
            `SPLC_CTRL: rd = 32'h0000_0000;
            `SPLC_STATUS: rd = {23'h00_0000, s_ff.dirty, s_ff.pw_init, s_ff.ss1, s_ff.tmode[0],
                s_ff.wr_refused, s_ff.auth_fail, s_ff.auth, s_ff.alarm1, s_ff.alarm0};
            `SPLC_AUTH_LO: rd = 32'h0000_0000;
            `SPLC_AUTH_HI: rd = 32'h0000_0000;
            `SPLC_NEWPW_LO: rd = 32'h0000_0000;
            `SPLC_NEWPW_HI: rd = 32'h0000_0000;
            `SPLC_AXIS: rd = {31'h0000_0000, s_ff.axis_sel};
            `SPLC_FORCE: rd = {23'h00_0000, s_ff.force_en, s_ff.force_val};
            `SPLC_ACTMODE:
            begin
                rd = {29'h0000_0000, cur.mode, cur.act};
                is_param = 1'b1;
            end
            `SPLC_CFG:
            begin
                rd = {16'h0000, cur.cfg};
                is_param = 1'b1;
            end
            `SPLC_DECEL:
            begin
                rd = {16'h0000, cur.decel};
                is_param = 1'b1;
            end
            `SPLC_ENC:
            begin
                rd = cur.enc;
                is_param = 1'b1;
            end
            `SPLC_SPEED:
            begin
                rd = {16'h0000, cur.speed};
                is_param = 1'b1;
            end
            `SPLC_POL:
            begin
                rd = {31'h0000_0000, cur.direction_polarity};
                is_param = 1'b1;
            end
            `SPLC_LNUM:
            begin
                rd = {16'h0000, cur.lnum};
                is_param = 1'b1;
            end
            `SPLC_LDEN:
            begin
                rd = {16'h0000, cur.lden};
                is_param = 1'b1;
            end
            default: unmapped = 1'b1;
        endcase

        // Write refusals
        if (pwrite)
        begin
            if (is_param && !s_ff.auth)
                refuse = 1'b1;
            if (addr == `SPLC_ENC && enc_refuse)
                refuse = 1'b1;
            if (addr == `SPLC_CTRL && pwdata[`SPLC_CTRL_PWSET] && (!s_ff.auth || !pw_valid))
                refuse = 1'b1;
            if (addr == `SPLC_FORCE && s_ff.tmode[0] == 1'b0)
                refuse = 1'b1;
        end

        // Access phase: answer with data and error
        if (access)
        begin
            nxt_s.pready = 1'b1;
            nxt_s.prdata = pwrite ? 32'h0000_0000 : rd;
            nxt_s.pslverr = unmapped || refuse;
        end

        // Write takes effect at the committing edge
        if (commit && pwrite && !unmapped)
        begin
            if (refuse)
                nxt_s.wr_refused = 1'b1;
            else
            begin
                for (int i = 0; i < 2; i++)
                begin
                    if (target[i] && is_param)
                    begin
                        nxt_s.dirty = 1'b1;
                        unique case (addr)
                            `SPLC_ACTMODE:
                            begin
                                nxt_s.pend[i].act = pwdata[0];
                                nxt_s.pend[i].mode = pwdata[2:1];
                            end
                            `SPLC_CFG: nxt_s.pend[i].cfg = pwdata[15:0];
                            `SPLC_DECEL: nxt_s.pend[i].decel = pwdata[15:0];
                            `SPLC_ENC: nxt_s.pend[i].enc = pwdata;
                            `SPLC_SPEED: nxt_s.pend[i].speed = pwdata[15:0];
                            `SPLC_POL: nxt_s.pend[i].direction_polarity = pwdata[0];
                            `SPLC_LNUM: nxt_s.pend[i].lnum = pwdata[15:0];
                            default: nxt_s.pend[i].lden = pwdata[15:0];
                        endcase
                    end
                end
                unique case (addr)
                    `SPLC_AUTH_LO: nxt_s.attempt[31:0] = pwdata;
                    `SPLC_AUTH_HI: nxt_s.attempt[47:32] = pwdata[15:0];
                    `SPLC_NEWPW_LO: nxt_s.newpw[31:0] = pwdata;
                    `SPLC_NEWPW_HI: nxt_s.newpw[47:32] = pwdata[15:0];
                    `SPLC_AXIS: nxt_s.axis_sel = pwdata[0];
                    `SPLC_FORCE:
                    begin
                        nxt_s.force_en = 1'b1;
                        nxt_s.force_val = pwdata[7:0];
                        if (!pwdata[`SPLC_FORCE_INDIV])
                        begin
                            // Pairs 1a/1b, 2a/2b, 3pa/3pb, 3na/3nb follow the A line
                            nxt_s.force_val[1] = pwdata[0];
                            nxt_s.force_val[3] = pwdata[2];
                            nxt_s.force_val[6] = pwdata[4];
                            nxt_s.force_val[7] = pwdata[5];
                        end
                    end
                    `SPLC_CTRL:
                    begin
                        if (pwdata[`SPLC_CTRL_AUTH])
                        begin
                            // Case-sensitive exact compare against the active password
                            nxt_s.auth = s_ff.attempt == s_ff.pw_act;
                            nxt_s.auth_fail = s_ff.attempt != s_ff.pw_act;
                            nxt_s.wr_refused = 1'b0;
                        end
                        if (pwdata[`SPLC_CTRL_PWSET])
                        begin
                            nxt_s.pw_pend = s_ff.newpw;
                            nxt_s.dirty = 1'b1;
                        end
                        if (pwdata[`SPLC_CTRL_PWINIT])
                            nxt_s.pw_init = 1'b1;
                        if (pwdata[`SPLC_CTRL_SWRST])
                        begin
                            // Software reset: apply pending values, drop session and alarms
                            if (s_ff.pw_init)
                            begin
                                nxt_s.pw_act = `SPLC_PW_DEFAULT;
                                nxt_s.pw_pend = `SPLC_PW_DEFAULT;
                                for (int i = 0; i < 2; i++)
                                begin
                                    nxt_s.pend[i] = '0;
                                    nxt_s.pend[i].decel = `SPLC_FACT_DECEL;
                                end
                            end
                            else
                                nxt_s.pw_act = s_ff.pw_pend;
                            nxt_s.act = nxt_s.pend;
                            nxt_s.pw_init = 1'b0;
                            nxt_s.dirty = 1'b0;
                            nxt_s.auth = 1'b0;
                            nxt_s.auth_fail = 1'b0;
                            nxt_s.wr_refused = 1'b0;
                            nxt_s.alarm0 = 1'b0;
                            nxt_s.alarm1 = 1'b0;
                            nxt_s.ss1 = 1'b0;
                            nxt_s.ss1_done = 1'b0;
                        end
                    end
                    default: nxt_s.axis_sel = s_ff.axis_sel;
                endcase
            end
        end

        // Setting-range alarm latches while a reset has not cleared it
        if (!(commit && pwrite && addr == `SPLC_CTRL && pwdata[`SPLC_CTRL_SWRST] && !refuse))
        begin
            nxt_s.alarm0 = s_ff.alarm0 | mismatch[0];
            nxt_s.alarm1 = s_ff.alarm1 | mismatch[1];
        end

        // Mode decode from the active set of each axis
        for (int i = 0; i < 2; i++)
        begin
            nxt_s.tmode[i] = nxt_s.act[i].mode == `SPLC_MODE_TEST;
            nxt_s.diag[i] = !nxt_s.tmode[i];
            nxt_s.sfen[i] = nxt_s.act[i].act && !nxt_s.tmode[i];
            nxt_s.direction_polarity[i] = nxt_s.act[i].direction_polarity;
        end
        nxt_s.restrict_cc = nxt_s.act[0].act || nxt_s.act[1].act;

        // Leaving test mode ends forced output
        if (!nxt_s.tmode[0])
            nxt_s.force_en = 1'b0;

        // Millisecond tick
        nxt_s.ms_cnt = (s_ff.ms_cnt == 16'(MS_CYCLES - 1)) ? 16'h0000 : s_ff.ms_cnt + 16'h0001;

        // Safe stop one on self-diagnosis error, decel monitor time in milliseconds
        if (selfdiag_error && !s_ff.ss1 && s_ff.sfen[0])
        begin
            nxt_s.ss1 = 1'b1;
            nxt_s.ss1_cnt = s_ff.act[0].decel;
        end
        else if (s_ff.ss1 && !s_ff.ss1_done && s_ff.ms_cnt == 16'h0000)
        begin
            if (s_ff.ss1_cnt == 16'h0000)
                nxt_s.ss1_done = 1'b1;
            else
                nxt_s.ss1_cnt = s_ff.ss1_cnt - 16'h0001;
        end

        // Safety output drive, forced value overrides servo status
        nxt_s.sout = nxt_s.force_en ? nxt_s.force_val : servo_out;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
            s_ff.pw_act <= `SPLC_PW_DEFAULT;
            s_ff.diag <= 2'b11;
            s_ff.pw_pend <= `SPLC_PW_DEFAULT;
            s_ff.pend[0].decel <= `SPLC_FACT_DECEL;
            s_ff.pend[1].decel <= `SPLC_FACT_DECEL;
            s_ff.act[0].decel <= `SPLC_FACT_DECEL;
            s_ff.act[1].decel <= `SPLC_FACT_DECEL;
        end
        else
            s_ff <= nxt_s;
    end

    // Outputs straight from the state register
    assign pready = s_ff.pready;
    assign prdata = s_ff.prdata;
    assign pslverr = s_ff.pslverr;
    assign setting_range_alarm = {s_ff.alarm1, s_ff.alarm0};
    assign test_mode = s_ff.tmode;
    assign io_diag_enable = s_ff.diag;
    assign safety_func_enable = s_ff.sfen;
    assign monitor_decreasing = s_ff.direction_polarity;
    assign comm_cycle_restricted = s_ff.restrict_cc;
    assign safe_stop_one = s_ff.ss1;
    assign ss1_decel_done = s_ff.ss1_done;
    assign safety_out = s_ff.sout;
endmodule

// File: core/splc_regs.svh
// Register offsets, field positions, reset values and timing counts of the safety parameter block
`ifndef SPLC_REGS_SVH
`define SPLC_REGS_SVH

// Register byte offsets
`define SPLC_CTRL 8'h00
`define SPLC_STATUS 8'h04
`define SPLC_AUTH_LO 8'h08
`define SPLC_AUTH_HI 8'h0C
`define SPLC_NEWPW_LO 8'h10
`define SPLC_NEWPW_HI 8'h14
`define SPLC_AXIS 8'h18
`define SPLC_FORCE 8'h1C
`define SPLC_ACTMODE 8'h20
`define SPLC_CFG 8'h24
`define SPLC_DECEL 8'h28
`define SPLC_ENC 8'h2C
`define SPLC_SPEED 8'h30
`define SPLC_POL 8'h34
`define SPLC_LNUM 8'h38
`define SPLC_LDEN 8'h3C

// Control register bits
`define SPLC_CTRL_SWRST 0
`define SPLC_CTRL_PWINIT 1
`define SPLC_CTRL_AUTH 2
`define SPLC_CTRL_PWSET 3

// Force register bits
`define SPLC_FORCE_INDIV 8

// Monitor field inside the functional safety setting
`define SPLC_CFG_MON_LSB 4
`define SPLC_CFG_MON_MSB 7

// Input mode codes
`define SPLC_MODE_TEST 2'h2

// Reset values
`define SPLC_PW_DEFAULT 48'h3030_3030_3030
`define SPLC_FACT_DECEL 16'h0000

// Timing: one decel monitor unit is one millisecond
`define SPLC_MS_NS 1000000
`define SPLC_CLK_NS 100

`endif

// File: core/splc_pkg.sv
// Types of the safety parameter block
package splc_pkg;

    // One safety parameter set
    typedef struct packed {
        logic act;
        logic [1:0] mode;
        logic [15:0] cfg;
        logic [15:0] decel;
        logic [31:0] enc;
        logic [15:0] speed;
        logic direction_polarity;
        logic [15:0] lnum;
        logic [15:0] lden;
    } splc_param_t;

endpackage

// File: core/splc_chk_if.sv
// Bundle between the top and one axis consistency checker
`timescale 1ns/100ps
interface splc_chk_if;
    splc_pkg::splc_param_t act;
    logic [31:0] motor_enc;
    logic [15:0] motor_speed;
    logic norm_dir;
    logic [15:0] norm_num;
    logic [15:0] norm_den;
    logic linear;
    logic mismatch;

    modport top (output act, motor_enc, motor_speed, norm_dir, norm_num, norm_den, linear, input mismatch);
    modport chk (input act, motor_enc, motor_speed, norm_dir, norm_num, norm_den, linear, output mismatch);
endinterface

// File: core/splc_check.sv
// Compares the active safety parameters of one axis against motor and normal parameters
`timescale 1ns/100ps
`include "splc_regs.svh"
module splc_check (
    // Checker side of the bundle
    splc_chk_if.chk c
);
    logic mon_used;
    logic bad_enc;
    logic bad_speed;
    logic bad_dir;
    logic bad_lin;

    // Position or speed monitoring selected
    assign mon_used = |c.act.cfg[`SPLC_CFG_MON_MSB:`SPLC_CFG_MON_LSB];

    // Individual mismatch terms
    assign bad_enc = c.act.enc != c.motor_enc;
    assign bad_speed = mon_used && (c.act.speed != c.motor_speed);
    assign bad_dir = c.act.direction_polarity != c.norm_dir;
    assign bad_lin = c.linear && mon_used && ((c.act.lnum != c.norm_num) || (c.act.lden != c.norm_den));

    // Checks apply only while the safety sub-functions are activated
    assign c.mismatch = c.act.act && (bad_enc || bad_speed || bad_dir || bad_lin);
endmodule

// File: core/splc_chk_if_note_placeholder_removed.sv
// Spare compilation unit, holds no logic

// File: dv/splc_props.sv
// Concurrent checks on the ports of the safety parameter block
`timescale 1ns/100ps
module splc_props #(
    parameter int MS_CYCLES = 4
) (
    // Clock, reset and bus answer
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic pready,
    // Unit inputs
    input wire logic selfdiag_error,
    input wire logic [7:0] servo_out,
    input wire logic [1:0] normal_travel_direction,
    // Safety status
    input wire logic [1:0] setting_range_alarm,
    input wire logic [1:0] test_mode,
    input wire logic [1:0] io_diag_enable,
    input wire logic [1:0] safety_func_enable,
    input wire logic [1:0] monitor_decreasing,
    input wire logic comm_cycle_restricted,
    input wire logic safe_stop_one,
    input wire logic ss1_decel_done,
    input wire logic [7:0] safety_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Answer lasts one cycle
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    diag_off_a: assert property (io_diag_enable == ~test_mode)
        else $error("diagnosis enable not inverse of test mode");
    func_off_a: assert property (test_mode[0] |-> !safety_func_enable[0])
        else $error("sub-functions enabled in test mode");
    comm_restrict_a: assert property (|safety_func_enable |-> comm_cycle_restricted)
        else $error("cycle not restricted while active");
    // Outside test mode the outputs follow normal drive
    force_gate_a: assert property (!test_mode[0] && $past(!test_mode[0]) && $past(presetn)
        |-> safety_out == $past(servo_out)) else $error("forced output outside test mode");
    ss1_start_a: assert property ($rose(safe_stop_one) |-> $past(selfdiag_error && safety_func_enable[0]))
        else $error("stop started without cause");
    ss1_done_a: assert property (ss1_decel_done |-> safe_stop_one) else $error("done without stop");
    pol_alarm_a: assert property ((safety_func_enable[0] && monitor_decreasing[0] != normal_travel_direction[0])[*2]
        |-> ##[0:2] setting_range_alarm[0]) else $error("polarity mismatch not flagged");
    alarm_hold_a: assert property ($fell(setting_range_alarm[0])
        |-> $past(pwrite && pready, 1) || $past(pwrite && pready, 2) || $past(pwrite && pready, 3))
        else $error("alarm cleared without reset");
endmodule

bind splc_top splc_props #(.MS_CYCLES(MS_CYCLES)) i_props (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
    .pready(pready), .selfdiag_error(selfdiag_error), .servo_out(servo_out),
    .normal_travel_direction(normal_travel_direction), .setting_range_alarm(setting_range_alarm),
    .test_mode(test_mode), .io_diag_enable(io_diag_enable), .safety_func_enable(safety_func_enable),
    .monitor_decreasing(monitor_decreasing), .comm_cycle_restricted(comm_cycle_restricted),
    .safe_stop_one(safe_stop_one), .ss1_decel_done(ss1_decel_done), .safety_out(safety_out));

// File: dv/splc_tool.sv
// Configuration tool model acting as bus master
`timescale 1ns/100ps
module splc_tool (
    // Bus clock and slave answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Bus request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end

    // One transfer: setup, access held until ready is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 32'(a);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// File: dv/splc_tb_top.sv
// Self-checking bench of the safety parameter block
`timescale 1ns/100ps
`include "splc_regs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module splc_tb_top;
    logic pclk, presetn, selfdiag_error, pready, pslverr, psel, penable, pwrite, comm, ss1, ss1_done, e, com = 1'b0;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [1:0][31:0] enc;
    logic [1:0][15:0] spd, num, den;
    logic [1:0] ndir, alarm, tmode, diag, func, mdec, lin = 2'b00;
    logic [7:0] servo, sout;
    logic [8:0] f;
    int n_errors = 0, tests_run = 0;

    splc_tool i_tool (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    splc_top #(.MS_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .motor_enc_res(enc), .motor_rated_speed(spd), .normal_travel_direction(ndir),
        .normal_lin_res_numerator(num), .normal_lin_res_denominator(den), .linear_motor(lin),
        .common_setting(com), .selfdiag_error(selfdiag_error), .servo_out(servo), .setting_range_alarm(alarm),
        .test_mode(tmode), .io_diag_enable(diag), .safety_func_enable(func), .monitor_decreasing(mdec),
        .comm_cycle_restricted(comm), .safe_stop_one(ss1), .ss1_decel_done(ss1_done), .safety_out(sout));

    // Clock of 100 ns
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Forced state expected on the eight lines
    function automatic logic [7:0] exp_force(input logic [8:0] v);
        return v[8] ? v[7:0] : {v[5], v[4], v[5:4], v[2], v[2], v[0], v[0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_tool.xfer(1'b1, a, d, q, e);
    endtask

    task automatic auth(input logic [15:0] hi);
        wr(`SPLC_AUTH_LO, 32'h3030_3030);
        wr(`SPLC_AUTH_HI, {16'h0000, hi});
        wr(`SPLC_CTRL, 32'h0000_0004);
    endtask

    // Software reset, then let outputs settle
    task automatic swrst();
        wr(`SPLC_CTRL, 32'h0000_0001);
        repeat (4) @(posedge pclk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        void'($urandom(7));
        presetn = 1'b0;
        selfdiag_error = 1'b0;
        enc = {$urandom, $urandom};
        spd = {16'($urandom), 16'($urandom)};
        num = {16'($urandom), 16'($urandom)};
        den = {16'($urandom), 16'($urandom)};
        ndir = 2'b00;
        servo = 8'($urandom);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("diag", 2'b11, diag)
        // Locked writes refused, reads always open
        wr(`SPLC_ACTMODE, 32'h0000_0001);
        `CHK("lock", 1'b1, e)
        i_tool.xfer(1'b0, `SPLC_ACTMODE, 32'h0000_0000, q, e);
        `CHK("read", 1'b0, e)
        auth(16'h3031);
        i_tool.xfer(1'b0, `SPLC_STATUS, 32'h0000_0000, q, e);
        `CHK("badpw", 2'b10, q[3:2])
        auth(16'h3030);
        i_tool.xfer(1'b0, `SPLC_STATUS, 32'h0000_0000, q, e);
        `CHK("pw0", 2'b01, q[3:2])
        $display("test lock done");
        // Activation applies only at software reset
        wr(`SPLC_ENC, enc[0]);
        lin <= 2'b01;
        wr(`SPLC_ENC, ~enc[0]);
        `CHK("encref", 1'b1, e)
        wr(`SPLC_ACTMODE, 32'h0000_0001);
        i_tool.xfer(1'b0, `SPLC_ACTMODE, 32'h0000_0000, q, e);
        `CHK("readback", 32'h0000_0001, q)
        `CHK("pending", 2'b00, func)
        swrst();
        `CHK("func", 2'b01, func)
        `CHK("comm", 1'b1, comm)
        `CHK("encok", 2'b00, alarm)
        selfdiag_error <= 1'b1;
        repeat (2) @(posedge pclk);
        selfdiag_error <= 1'b0;
        `CHK("ss1", 1'b1, ss1)
        repeat (16) @(posedge pclk);
        `CHK("ss1done", 1'b1, ss1_done)
        $display("test activate done");
        // Polarity mismatch latches the alarm
        auth(16'h3030);
        com <= 1'b1;
        wr(`SPLC_POL, 32'h0000_0001);
        com <= 1'b0;
        swrst();
        `CHK("polalarm", 1'b1, alarm[0])
        `CHK("mondec", 2'b11, mdec)
        repeat (10) @(posedge pclk);
        `CHK("latch", 1'b1, alarm[0])
        $display("test polarity done");
        // Test mode and forced outputs
        auth(16'h3030);
        wr(`SPLC_POL, 32'h0000_0000);
        wr(`SPLC_ACTMODE, 32'h0000_0005);
        wr(`SPLC_FORCE, 32'h0000_00ff);
        `CHK("noforce", 1'b1, e)
        swrst();
        `CHK("tmode", 1'b1, tmode[0])
        `CHK("clear", 2'b00, alarm)
        for (int i = 0; i < 6; i++)
        begin
            f = {i[0], 8'($urandom)};
            servo <= 8'($urandom);
            wr(`SPLC_FORCE, {23'h00_0000, f});
            repeat (2) @(posedge pclk);
            `CHK("force", exp_force(f), sout)
        end
        auth(16'h3030);
        wr(`SPLC_ACTMODE, 32'h0000_0001);
        swrst();
        `CHK("leave", 1'b0, tmode[0])
        `CHK("normal", servo, sout)
        $display("test force done");
        stop_test();
    end
endmodule
